// File: pkg/omwd_pkg.sv
package omwd_pkg;

  localparam int ADDR_W = 24;
  localparam int SOCKET_BIT = 11;
  localparam int BASE_LSB = 12;
  localparam int BASE_MSB = 15;
  localparam int SEG_LSB = 16;
  localparam int SEG_MSB = 23;
  localparam int GRP_BANK_BIT = 2;

  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] HITS_OFF = 12'h008;
  localparam logic [11:0] SWITCH_OFF = 12'h00C;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] HITS_RST = 16'h0000;
  localparam logic BANK_RAW_RST = 1'b0;

  localparam int ST_BANK_EN = 0;
  localparam int ST_PHANTOM = 1;
  localparam int ST_EXT_ON = 2;
  localparam int ST_CS_LEFT = 3;
  localparam int ST_CS_RIGHT = 4;
  localparam int ST_LAST_UPPER = 5;

  typedef enum logic [1:0] {
    OMWD_IDLE = 2'b00,
    OMWD_HIT = 2'b01,
    OMWD_MISS = 2'b10
  } omwd_cyc_t;

  // every switch field: 1 = paddle open, 0 = paddle closed
  typedef struct packed {
    logic [3:0] base;
    logic [7:0] segment;
    logic ext_open;
    logic polarity_open;
    logic phantom_open;
  } omwd_sw_t;

  typedef struct packed {
    logic cycle;
    logic read;
    logic [ADDR_W-1:0] addr;
    logic phantom_n;
  } omwd_mem_t;

endpackage

// File: rtl/omwd_addr_match.sv
`timescale 1ns/1ps
module omwd_addr_match (
  input omwd_pkg::omwd_mem_t mem,
  input omwd_pkg::omwd_sw_t sw,
  output logic hit,
  output logic upper
);

  logic base_ok;
  logic seg_ok;

  always_comb begin
    // closed paddle needs a zero bit, open paddle a one bit
    base_ok = (mem.addr[omwd_pkg::BASE_MSB:omwd_pkg::BASE_LSB] == sw.base);
    // segment compare only counts while extended decode is open
    seg_ok = !sw.ext_open || (mem.addr[omwd_pkg::SEG_MSB:omwd_pkg::SEG_LSB] == sw.segment);
    hit = base_ok && seg_ok;
    upper = mem.addr[omwd_pkg::SOCKET_BIT];
  end

endmodule

// File: rtl/omwd_bank_ctl.sv
`timescale 1ns/1ps
module omwd_bank_ctl (
  input logic pclk,
  input logic presetn,
  input logic wr,
  input logic wr_bit,
  input logic polarity_open,
  output logic bank_en
);

  typedef struct packed {
    logic raw;
  } omwd_bank_state_t;

  omwd_bank_state_t st;
  omwd_bank_state_t next_st;

  always_comb begin
    next_st = st;
    if (wr) begin
      next_st.raw = wr_bit;
    end
  end

  // raw resets to zero so the strap alone picks the reset state, no port sampled under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.raw <= omwd_pkg::BANK_RAW_RST;
    end else begin
      st <= next_st;
    end
  end

  // closed: active low, enabled at reset; open: active high, disabled at reset
  assign bank_en = st.raw ~^ polarity_open;

endmodule

// File: rtl/omwd_decoder.sv
`timescale 1ns/1ps
module omwd_decoder (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input omwd_pkg::omwd_mem_t mem,
  input omwd_pkg::omwd_sw_t sw,
  input logic io_grp_wr,
  input logic [7:0] io_data,
  output logic cs_left,
  output logic cs_right,
  output logic data_oe,
  output logic wait_req
);

  typedef struct packed {
    omwd_pkg::omwd_cyc_t cyc;
    logic cs_left;
    logic cs_right;
    logic data_oe;
    logic last_upper;
    logic [7:0] ctrl_image;
    logic [15:0] hits;
    logic [31:0] prdata;
  } omwd_state_t;

  omwd_state_t st;
  omwd_state_t next_st;

  logic hit;
  logic upper;
  logic bank_en;
  logic grp_wr;
  logic grp_bit;
  logic phantom_block;
  logic sel_ok;
  logic apb_setup;
  logic apb_access;
  logic ctrl_wr;
  logic hits_wr;

  function automatic logic reg_mapped(input logic [11:0] a);
    reg_mapped = (a == omwd_pkg::CTRL_OFF) || (a == omwd_pkg::STATUS_OFF) ||
                 (a == omwd_pkg::HITS_OFF) || (a == omwd_pkg::SWITCH_OFF);
  endfunction

  function automatic logic [31:0] reg_read(input logic [11:0] a, input omwd_state_t s,
                                           input logic ben, input logic pb, input omwd_pkg::omwd_sw_t w);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      omwd_pkg::CTRL_OFF: begin
        v[7:0] = s.ctrl_image;
      end
      omwd_pkg::STATUS_OFF: begin
        v[omwd_pkg::ST_BANK_EN] = ben;
        v[omwd_pkg::ST_PHANTOM] = pb;
        v[omwd_pkg::ST_EXT_ON] = w.ext_open;
        v[omwd_pkg::ST_CS_LEFT] = s.cs_left;
        v[omwd_pkg::ST_CS_RIGHT] = s.cs_right;
        v[omwd_pkg::ST_LAST_UPPER] = s.last_upper;
      end
      omwd_pkg::HITS_OFF: begin
        v[15:0] = s.hits;
      end
      omwd_pkg::SWITCH_OFF: begin
        v[14:0] = w;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    reg_read = v;
  endfunction

  omwd_addr_match u_match (
    .mem(mem),
    .sw(sw),
    .hit(hit),
    .upper(upper)
  );

  // a host bus write and a register write in one cycle: the host bus write wins
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign ctrl_wr = apb_access && pwrite && (paddr == omwd_pkg::CTRL_OFF);
  assign hits_wr = apb_access && pwrite && (paddr == omwd_pkg::HITS_OFF);
  assign grp_wr = io_grp_wr || ctrl_wr;
  assign grp_bit = io_grp_wr ? io_data[omwd_pkg::GRP_BANK_BIT] : pwdata[omwd_pkg::GRP_BANK_BIT];

  omwd_bank_ctl u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .wr(grp_wr),
    .wr_bit(grp_bit),
    .polarity_open(sw.polarity_open),
    .bank_en(bank_en)
  );

  assign phantom_block = !mem.phantom_n && !sw.phantom_open;
  assign sel_ok = mem.cycle && hit && bank_en && !phantom_block;

  always_comb begin
    next_st = st;
    next_st.cs_left = sel_ok && !upper;
    next_st.cs_right = sel_ok && upper;
    next_st.data_oe = sel_ok && mem.read;
    if (io_grp_wr) begin
      next_st.ctrl_image = io_data;
    end else if (ctrl_wr) begin
      next_st.ctrl_image = pwdata[7:0];
    end
    if (hits_wr) begin
      next_st.hits = omwd_pkg::HITS_RST;
    end
    case (st.cyc)
      omwd_pkg::OMWD_IDLE: begin
        if (mem.cycle && sel_ok) begin
          next_st.cyc = omwd_pkg::OMWD_HIT;
          next_st.last_upper = upper;
          // a same-cycle clear restarts the count at one, counting this hit
          next_st.hits = hits_wr ? 16'h0001 : st.hits + 16'h0001;
        end else if (mem.cycle) begin
          next_st.cyc = omwd_pkg::OMWD_MISS;
        end
      end
      omwd_pkg::OMWD_HIT, omwd_pkg::OMWD_MISS: begin
        if (!mem.cycle) begin
          next_st.cyc = omwd_pkg::OMWD_IDLE;
        end
      end
      default: begin
        next_st.cyc = omwd_pkg::OMWD_IDLE;
      end
    endcase
    // read data captured in setup so the access phase needs no wait
    if (apb_setup && !pwrite) begin
      next_st.prdata = reg_read(paddr, st, bank_en, phantom_block, sw);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.cyc <= omwd_pkg::OMWD_IDLE;
      st.cs_left <= 1'b0;
      st.cs_right <= 1'b0;
      st.data_oe <= 1'b0;
      st.last_upper <= 1'b0;
      st.ctrl_image <= omwd_pkg::CTRL_RST;
      st.hits <= omwd_pkg::HITS_RST;
      st.prdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign cs_left = st.cs_left;
  assign cs_right = st.cs_right;
  assign data_oe = st.data_oe;
  // memory is fast enough for the bus; slow parts need host-side waits
  assign wait_req = 1'b0;
  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = apb_access && !reg_mapped(paddr);

  logic low_match;
  assign low_match = mem.addr[omwd_pkg::BASE_MSB:omwd_pkg::BASE_LSB] == sw.base;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wait_never_a: assert property (!wait_req)
    else $error("wait state requested");

  socket_left_a: assert property (cs_left |-> !$past(mem.addr[omwd_pkg::SOCKET_BIT]))
    else $error("left socket selected with A11 high");

  socket_right_a: assert property (cs_right |-> $past(mem.addr[omwd_pkg::SOCKET_BIT]))
    else $error("right socket selected with A11 low");

  socket_excl_a: assert property (!(cs_left && cs_right))
    else $error("both sockets selected");

  base_match_a: assert property ((cs_left || cs_right) |->
    $past(mem.addr[omwd_pkg::BASE_MSB:omwd_pkg::BASE_LSB]) == $past(sw.base))
    else $error("select without base match");

  seg_match_a: assert property ((cs_left || cs_right) && $past(sw.ext_open) |->
    $past(mem.addr[omwd_pkg::SEG_MSB:omwd_pkg::SEG_LSB]) == $past(sw.segment))
    else $error("select without segment match");

  seg_ignore_a: assert property (mem.cycle && !sw.ext_open && low_match && bank_en && !phantom_block
    |=> cs_left || cs_right)
    else $error("no select with extended decode off");

  bank_gate_a: assert property ((cs_left || cs_right) |-> $past(bank_en))
    else $error("select while bank disabled");

  phantom_off_a: assert property (mem.cycle && !mem.phantom_n && !sw.phantom_open
    |=> !cs_left && !cs_right)
    else $error("select during phantom");

  bank_write_a: assert property (io_grp_wr ##1 $stable(sw.polarity_open)
    |-> bank_en == ($past(io_data[omwd_pkg::GRP_BANK_BIT]) ~^ sw.polarity_open))
    else $error("bank bit not loaded");

  bank_reset_a: assert property ($rose(presetn) |-> bank_en == !sw.polarity_open)
    else $error("bank reset state wrong");

  data_drive_a: assert property (data_oe |-> $past(mem.cycle && mem.read) && (cs_left || cs_right))
    else $error("data driven outside matching read");

  left_pick_a: assert property (sel_ok && !upper |=> cs_left)
    else $error("left socket not selected on match");

  right_pick_a: assert property (sel_ok && upper |=> cs_right)
    else $error("right socket not selected on match");

  idle_quiet_a: assert property (!mem.cycle |=> !cs_left && !cs_right && !data_oe)
    else $error("select outside a memory cycle");

  seg_block_a: assert property (mem.cycle && sw.ext_open &&
    mem.addr[omwd_pkg::SEG_MSB:omwd_pkg::SEG_LSB] != sw.segment |=> !cs_left && !cs_right)
    else $error("select despite segment mismatch");

  read_drive_a: assert property (sel_ok && mem.read |=> data_oe)
    else $error("matched read not driven");

  write_quiet_a: assert property (!mem.read |=> !data_oe)
    else $error("data driven on a write");

  ctrl_load_a: assert property (io_grp_wr |=> st.ctrl_image == $past(io_data))
    else $error("group image not loaded");

  apb_bank_a: assert property (ctrl_wr && !io_grp_wr ##1 $stable(sw.polarity_open) |->
    bank_en == ($past(pwdata[omwd_pkg::GRP_BANK_BIT]) ~^ sw.polarity_open))
    else $error("bank bit not loaded from register write");

  bank_hold_a: assert property (!grp_wr ##1 $stable(sw.polarity_open) |-> $stable(bank_en))
    else $error("bank state moved without a group write");

  polarity_flip_a: assert property (!grp_wr ##1 $changed(sw.polarity_open) |-> $changed(bank_en))
    else $error("polarity flip did not flip bank state");

  hit_count_a: assert property (st.cyc == omwd_pkg::OMWD_IDLE && sel_ok && !hits_wr |=>
    st.hits == $past(st.hits) + 16'h0001)
    else $error("hit not counted");

  hit_clear_a: assert property (hits_wr && !(st.cyc == omwd_pkg::OMWD_IDLE && sel_ok) |=>
    st.hits == omwd_pkg::HITS_RST)
    else $error("hit count not cleared");

  hit_hold_a: assert property (!(st.cyc == omwd_pkg::OMWD_IDLE && sel_ok) && !hits_wr |=> $stable(st.hits))
    else $error("hit count moved without a hit");

  last_side_a: assert property (st.cyc == omwd_pkg::OMWD_IDLE && sel_ok |=> st.last_upper == $past(upper))
    else $error("last socket not recorded");

  rd_load_a: assert property (apb_setup && !pwrite && !reg_mapped(paddr) |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  rd_hold_a: assert property (!(apb_setup && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read setup");

  left_hit_c: cover property (mem.cycle && sel_ok && !upper ##1 cs_left);
  right_hit_c: cover property (mem.cycle && sel_ok && upper ##1 cs_right);
  ext_hit_c: cover property (sw.ext_open && sel_ok);
  phantom_c: cover property (mem.cycle && hit && bank_en && phantom_block);
  ctrl_bank_c: cover property (ctrl_wr && !io_grp_wr);

endmodule

// File: testbench/omwd_host_model.sv
`timescale 1ns/1ps
module omwd_host_model (
  input wire logic pclk,
  output omwd_pkg::omwd_mem_t mem
);
  initial mem = '{cycle: 1'b0, read: 1'b0, addr: 24'h5A5A5A, phantom_n: 1'b1};
  // slow parts: the host stretches its own cycle, the card never does
  task automatic access(input logic [23:0] a, input logic rd, input logic ph_n, input int waits);
    @(posedge pclk);
    mem <= '{cycle: 1'b1, read: rd, addr: a, phantom_n: ph_n};
    repeat (1 + waits) @(posedge pclk);
    mem.cycle <= 1'b0;
    mem.addr <= ~a; // released bus shows no stale address
    mem.phantom_n <= 1'b1;
  endtask
endmodule

// File: testbench/tb_omwd_decoder.sv
`timescale 1ns/1ps
module tb_omwd_decoder;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, io_grp_wr, cs_left, cs_right, data_oe, wait_req;
  logic [7:0] io_data;
  omwd_pkg::omwd_mem_t mem;
  omwd_pkg::omwd_sw_t sw;
  int failures = 0;
  int cmp_count = 0;
  omwd_host_model u_host (.pclk(pclk), .mem(mem));
  omwd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem(mem),
    .sw(sw), .io_grp_wr(io_grp_wr), .io_data(io_data), .cs_left(cs_left), .cs_right(cs_right),
    .data_oe(data_oe), .wait_req(wait_req));
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic grp(input logic [7:0] d);
    @(posedge pclk);
    io_grp_wr <= 1'b1;
    io_data <= d;
    @(posedge pclk);
    io_grp_wr <= 1'b0;
  endtask
  // exp = {right, left}; data drive only on a selected read
  task automatic hit(input logic [23:0] a, input logic r, input logic ph_n, input logic [1:0] exp);
    u_host.access(a, r, ph_n, 1);
    #1;
    chk("cs_left", cs_left, exp[0]);
    chk("cs_right", cs_right, exp[1]);
    chk("data_oe", data_oe, r & |exp);
    chk("wait_req", wait_req, 1'b0);
  endtask
  task automatic t_base();
    hit(24'h00C000, 1'b1, 1'b1, 2'b01);
    hit(24'h00C7FF, 1'b0, 1'b1, 2'b01);
    hit(24'h00C800, 1'b1, 1'b1, 2'b10);
    hit(24'h00CFFF, 1'b0, 1'b1, 2'b10);
    hit(24'h00D000, 1'b1, 1'b1, 2'b00);
    hit(24'h00BFFF, 1'b1, 1'b1, 2'b00);
    hit(24'hA5C000, 1'b1, 1'b1, 2'b01);
  endtask
  task automatic t_ext();
    @(posedge pclk) sw.ext_open <= 1'b1;
    hit(24'h10C000, 1'b1, 1'b1, 2'b01);
    hit(24'h10C800, 1'b0, 1'b1, 2'b10);
    hit(24'h00C000, 1'b1, 1'b1, 2'b00);
    hit(24'h90C000, 1'b1, 1'b1, 2'b00);
    @(posedge pclk) sw.ext_open <= 1'b0;
  endtask
  task automatic t_bank();
    grp(8'h04);
    apb(1'b0, omwd_pkg::STATUS_OFF, 32'h0);
    chk("bank_en", rd[0], 1'b0);
    hit(24'h00C000, 1'b1, 1'b1, 2'b00);
    apb(1'b1, omwd_pkg::CTRL_OFF, 32'h0);
    hit(24'h00C000, 1'b1, 1'b1, 2'b01);
    @(posedge pclk) sw.polarity_open <= 1'b1;
    hit(24'h00C800, 1'b1, 1'b1, 2'b00);
    grp(8'h04);
    hit(24'h00C800, 1'b1, 1'b1, 2'b10);
    @(posedge pclk) sw.polarity_open <= 1'b0;
    grp(8'h00);
  endtask
  task automatic t_phantom();
    hit(24'h00C000, 1'b1, 1'b0, 2'b00);
    @(posedge pclk) sw.phantom_open <= 1'b1;
    hit(24'h00C000, 1'b1, 1'b0, 2'b01);
  endtask
  task automatic t_apb();
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", err, 1'b1);
    chk("prdata", rd, 32'h0);
    apb(1'b0, omwd_pkg::SWITCH_OFF, 32'h0);
    chk("switch", rd, {17'h0, sw});
    apb(1'b0, omwd_pkg::HITS_OFF, 32'h0);
    chk("hits", rd, 32'h0000_000A);
    apb(1'b1, omwd_pkg::HITS_OFF, 32'h0);
    apb(1'b0, omwd_pkg::HITS_OFF, 32'h0);
    chk("hits_clr", rd, 32'h0000_0000);
  endtask
  // second reset with the polarity paddle open: bank must come up disabled
  task automatic t_reset();
    @(posedge pclk);
    sw.polarity_open <= 1'b1;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    hit(24'h00C000, 1'b1, 1'b1, 2'b00);
    apb(1'b0, omwd_pkg::STATUS_OFF, 32'h0);
    chk("bank_en_rst", rd[0], 1'b0);
    grp(8'h04);
    hit(24'h00C800, 1'b0, 1'b1, 2'b10);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #20000;
    failures++;
    stop_test();
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, io_grp_wr} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    io_data = 8'h00;
    sw = '{base: 4'hC, segment: 8'h10, ext_open: 1'b0, polarity_open: 1'b0, phantom_open: 1'b0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_base();
    t_ext();
    t_bank();
    t_phantom();
    t_apb();
    t_reset();
    stop_test();
  end
endmodule
